// ---- rtl/daa_line_cfg.svh ----
// Offsets, field positions, reset values and level codes of the line status block.
`ifndef DAA_LINE_CFG_SVH
`define DAA_LINE_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_STATUS 12'h000
`define OFS_CTRL 12'h004
`define OFS_GAIN 12'h008
`define OFS_RATE 12'h00c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ST_LEVEL_LSB 0
`define ST_DROPOUT_BIT 8
`define ST_OVERLOAD_BIT 9
`define ST_REV_LSB 16
`define CT_OPE_BIT 0
`define CT_DOD_MASK_BIT 1
`define CT_IIR_BIT 2
`define CT_LOOP_LSB 4
`define GN_RX_LSB 0
`define GN_RX_MUTE_BIT 7
`define GN_TX_LSB 8
`define GN_TX_MUTE_BIT 15
`define RT_IDX_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_LOOP 3'h0
`define RST_GAIN 3'h0
`define RST_RATE_IDX 4'h1

// ----------------------------------------------------------------
// Loop current codes and scale
// ----------------------------------------------------------------
`define LVL_NONE 5'h00
`define LVL_MIN 5'h04
`define LVL_MAX 5'h1f
`define UA_PER_STEP 17'h00ce4
`define DB_PER_STEP 4'h3
`define GAIN_MAX_CODE 3'h4
`define RATE_LAST_IDX 4'h9

// ----------------------------------------------------------------
// Loopback codes
// ----------------------------------------------------------------
`define LB_NORMAL 3'h0
`define LB_ADC 3'h1
`define LB_LOCAL_ANALOG 3'h2
`define LB_DAC 3'h3
`define LB_REMOTE_ANALOG 3'h4
`define LB_LINK 3'h5
`define LB_EXT_ANALOG 3'h6

// ----------------------------------------------------------------
// Sample rates in Hz
// ----------------------------------------------------------------
`define RATE_0 16'h1c20
`define RATE_1 16'h1f40
`define RATE_2 16'h2025
`define RATE_3 16'h20d0
`define RATE_4 16'h2328
`define RATE_5 16'h2580
`define RATE_6 16'h282e
`define RATE_7 16'h2ee0
`define RATE_8 16'h3592
`define RATE_9 16'h3e80

`endif

// ---- rtl/daa_line_pkg.sv ----
// Types of the line status and test control block.
`default_nettype none
package daa_line_pkg;

  typedef enum logic [1:0] {
    PROT_IDLE = 2'b01,
    PROT_ACTIVE = 2'b10
  } prot_state_t;

  typedef struct packed {
    logic hook_s1;
    logic hook_s2;
    logic hook_s3;
    logic [4:0] lvl_s1;
    logic [4:0] lvl_s2;
    logic [3:0] rev_s1;
    logic [3:0] rev_s2;
    logic [4:0] level;
    logic [16:0] current_ua;
    logic dropout;
    logic overload;
    prot_state_t prot;
    logic term800;
    logic overload_protect_enable;
    logic dod_mask;
    logic iir;
    logic [2:0] loop;
    logic [2:0] rx_gain;
    logic rx_mute;
    logic [2:0] tx_att;
    logic tx_mute;
    logic [3:0] rate_idx;
    logic [15:0] rate_hz;
    logic [3:0] rx_db;
    logic [3:0] tx_db;
    logic [5:0] loop_path;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

endpackage
`default_nettype wire

// ---- rtl/daa_line_ctrl.sv ----
// Loop current status, overload protection, gain, rate, filter and loopback control with APB slave.
//
// Operation
// - While off-hook, show the measured loop current as a 5-bit readable field.
// - One step of the level field stands for 3.3 mA.
// - Readings below the minimum operating current are undefined.
// - Code zero means too little current; software checks the dropout flag.
// - Code four marks the minimum current for normal operation.
// - Code all ones means possible excess; software checks the overload flag.
// - Enabled overload sets flag, selects 800 ohm termination, reduces hook current.
// - A 3-bit field picks receive gain of 0 to 12 dB.
// - Bit 7 of the receive setting mutes the receive path.
// - A 3-bit field picks transmit attenuation of 0 to 12 dB.
// - Bit 7 of the transmit setting mutes the transmit path.
// - The rate setting selects one of ten sample rates.
// - A select bit chooses the recursive filter; the FIR filter is default.
// - Code 101 loops outgoing data across the isolation link and back.
// - Code 011 loops outgoing data through the digital DAC section.
// - Code 100 loops external receive pins to transmit pins on the line side.
// - Code 001 digitizes external receive signal, returns it to transmit pins.
// - Code 010 loops controller data through line-side analog internally.
// - Code 110 drives test data onto the line and returns it.
// - A 4-bit read-only field reports the line chip revision.
// - Collapse below minimum sets the dropout flag and a masked interrupt.
`include "daa_line_cfg.svh"
`default_nettype none
module daa_line_ctrl (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Line side measurements
  input wire logic off_hook,
  input wire logic [4:0] line_current_code,
  input wire logic [3:0] line_chip_revision,
  // Line status
  output logic [4:0] loop_current_level,
  output logic [16:0] loop_current_ua,
  output logic line_dropout_flag,
  output logic overload_detected_flag,
  output logic dropout_irq,
  // Protection
  output logic dc_term_800,
  output logic hook_current_reduce,
  // Signal path
  output logic [3:0] rx_gain_db,
  output logic rx_mute,
  output logic [3:0] tx_atten_db,
  output logic tx_mute,
  output logic recursive_filter_select,
  output logic [15:0] sample_rate_hz,
  output logic [2:0] loopback_select,
  output logic [5:0] loopback_path
);

  daa_line_pkg::state_t s;
  daa_line_pkg::state_t n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rate_of(input logic [3:0] idx);
    logic [15:0] r;
    r = `RATE_1;
    case (idx)
      4'h0: r = `RATE_0;
      4'h1: r = `RATE_1;
      4'h2: r = `RATE_2;
      4'h3: r = `RATE_3;
      4'h4: r = `RATE_4;
      4'h5: r = `RATE_5;
      4'h6: r = `RATE_6;
      4'h7: r = `RATE_7;
      4'h8: r = `RATE_8;
      4'h9: r = `RATE_9;
      default: r = `RATE_1;
    endcase
    return r;
  endfunction

  // Codes above the top step clamp to the top step rather than wrap.
  function automatic logic [3:0] db_of(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `GAIN_MAX_CODE) ? `GAIN_MAX_CODE : code;
    return 4'(c) * `DB_PER_STEP;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic hit_st;
  logic hit_ct;
  logic hit_gn;
  logic hit_rt;
  logic clr_dod;
  logic clr_opd;
  logic set_dod;
  logic set_opd;
  logic [31:0] rd;

  always_comb begin
    n = s;
    setup = psel & ~penable;
    wr = psel & penable & pwrite & s.pready;
    hit_st = paddr == `OFS_STATUS;
    hit_ct = paddr == `OFS_CTRL;
    hit_gn = paddr == `OFS_GAIN;
    hit_rt = paddr == `OFS_RATE;

    // Two-flop synchronisers; the level code is taken as a quasi-static bus.
    n.hook_s1 = off_hook;
    n.hook_s2 = s.hook_s1;
    n.hook_s3 = s.hook_s2;
    n.lvl_s1 = line_current_code;
    n.lvl_s2 = s.lvl_s1;
    n.rev_s1 = line_chip_revision;
    n.rev_s2 = s.rev_s1;

    // Level reads zero on-hook; below the minimum it is passed unqualified.
    n.level = s.hook_s2 ? s.lvl_s2 : `LVL_NONE;
    n.current_ua = 17'(s.level) * `UA_PER_STEP;

    // Sticky flags, write one to clear; a set in the same cycle wins.
    clr_dod = wr & hit_st & pstrb[1] & pwdata[`ST_DROPOUT_BIT];
    clr_opd = wr & hit_st & pstrb[1] & pwdata[`ST_OVERLOAD_BIT];
    // The level register trails the hook by one edge; without the older hook stage going off-hook flags a dropout.
    set_dod = s.hook_s3 & s.hook_s2 & (s.level < `LVL_MIN);
    set_opd = 1'b0;
    n.dropout = (s.dropout & ~clr_dod) | set_dod;

    // Overload protection holds the 800 ohm termination until the flag is cleared.
    case (s.prot)
      daa_line_pkg::PROT_IDLE: begin
        if (s.overload_protect_enable & s.hook_s2 & (s.level == `LVL_MAX)) begin
          set_opd = 1'b1;
          n.prot = daa_line_pkg::PROT_ACTIVE;
        end
      end
      daa_line_pkg::PROT_ACTIVE: begin
        if (~s.overload | clr_opd) begin
          n.prot = daa_line_pkg::PROT_IDLE;
        end
      end
      default: begin
        n.prot = daa_line_pkg::PROT_IDLE;
      end
    endcase
    n.overload = (s.overload & ~clr_opd) | set_opd;
    n.term800 = n.prot == daa_line_pkg::PROT_ACTIVE;
    n.irq = n.dropout & s.dod_mask;

    // Control writes.
    if (wr & hit_ct & pstrb[0]) begin
      n.overload_protect_enable = pwdata[`CT_OPE_BIT];
      n.dod_mask = pwdata[`CT_DOD_MASK_BIT];
      n.iir = pwdata[`CT_IIR_BIT];
      n.loop = pwdata[`CT_LOOP_LSB +: 3];
    end
    if (wr & hit_gn & pstrb[0]) begin
      n.rx_gain = pwdata[`GN_RX_LSB +: 3];
      n.rx_mute = pwdata[`GN_RX_MUTE_BIT];
    end
    if (wr & hit_gn & pstrb[1]) begin
      n.tx_att = pwdata[`GN_TX_LSB +: 3];
      n.tx_mute = pwdata[`GN_TX_MUTE_BIT];
    end
    // Out-of-range rate indices are refused so the converter never runs unset.
    if (wr & hit_rt & pstrb[0] & (pwdata[`RT_IDX_LSB +: 4] <= `RATE_LAST_IDX)) begin
      n.rate_idx = pwdata[`RT_IDX_LSB +: 4];
    end

    n.rx_db = db_of(n.rx_gain);
    n.tx_db = db_of(n.tx_att);
    n.rate_hz = rate_of(n.rate_idx);

    // Loopback path decode, one bit per test path.
    case (n.loop)
      `LB_LINK: n.loop_path = 6'h01;
      `LB_DAC: n.loop_path = 6'h02;
      `LB_REMOTE_ANALOG: n.loop_path = 6'h04;
      `LB_ADC: n.loop_path = 6'h08;
      `LB_LOCAL_ANALOG: n.loop_path = 6'h10;
      `LB_EXT_ANALOG: n.loop_path = 6'h20;
      default: n.loop_path = 6'h00;
    endcase

    // Read mux, sampled in the setup cycle so prdata is a flop in the access cycle.
    rd = 32'h0000_0000;
    if (hit_st) begin
      rd[`ST_LEVEL_LSB +: 5] = s.level;
      rd[`ST_DROPOUT_BIT] = s.dropout;
      rd[`ST_OVERLOAD_BIT] = s.overload;
      rd[`ST_REV_LSB +: 4] = s.rev_s2;
    end else if (hit_ct) begin
      rd[`CT_OPE_BIT] = s.overload_protect_enable;
      rd[`CT_DOD_MASK_BIT] = s.dod_mask;
      rd[`CT_IIR_BIT] = s.iir;
      rd[`CT_LOOP_LSB +: 3] = s.loop;
    end else if (hit_gn) begin
      rd[`GN_RX_LSB +: 3] = s.rx_gain;
      rd[`GN_RX_MUTE_BIT] = s.rx_mute;
      rd[`GN_TX_LSB +: 3] = s.tx_att;
      rd[`GN_TX_MUTE_BIT] = s.tx_mute;
    end else if (hit_rt) begin
      rd[`RT_IDX_LSB +: 4] = s.rate_idx;
    end
    n.pready = setup;
    n.pslverr = setup & ~(hit_st | hit_ct | hit_gn | hit_rt);
    if (setup) begin
      n.prdata = pwrite ? 32'h0000_0000 : rd;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.prot <= daa_line_pkg::PROT_IDLE;
      s.loop <= `RST_LOOP;
      s.rx_gain <= `RST_GAIN;
      s.tx_att <= `RST_GAIN;
      s.rate_idx <= `RST_RATE_IDX;
      s.rate_hz <= `RATE_1;
    end else if (ce) begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign prdata = s.prdata;
  assign loop_current_level = s.level;
  assign loop_current_ua = s.current_ua;
  assign line_dropout_flag = s.dropout;
  assign overload_detected_flag = s.overload;
  assign dropout_irq = s.irq;
  assign dc_term_800 = s.term800;
  assign hook_current_reduce = s.term800;
  assign rx_gain_db = s.rx_db;
  assign rx_mute = s.rx_mute;
  assign tx_atten_db = s.tx_db;
  assign tx_mute = s.tx_mute;
  assign recursive_filter_select = s.iir;
  assign sample_rate_hz = s.rate_hz;
  assign loopback_select = s.loop;
  assign loopback_path = s.loop_path;

endmodule
`default_nettype wire

// ---- sim/daa_line_props.sv ----
// Concurrent checks on the ports of the line status and test control block.
`include "daa_line_cfg.svh"
`default_nettype none
module daa_line_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // Line status and controls
  input wire logic off_hook,
  input wire logic [4:0] loop_current_level,
  input wire logic [16:0] loop_current_ua,
  input wire logic line_dropout_flag,
  input wire logic overload_detected_flag,
  input wire logic dropout_irq,
  input wire logic dc_term_800,
  input wire logic hook_current_reduce,
  input wire logic [3:0] rx_gain_db,
  input wire logic rx_mute,
  input wire logic tx_mute,
  input wire logic [2:0] loopback_select,
  input wire logic [5:0] loopback_path
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The level passes two sync stages and one register, so it trails the hook pin by three edges.
  property p_level_hook; loop_current_level != 5'h00 |-> $past(off_hook, 3); endproperty
  a_level_hook: assert property (p_level_hook) else $error("level shown while on-hook");
  property p_scale; loop_current_ua == 17'($past(loop_current_level)) * 17'h00ce4; endproperty
  a_scale: assert property (p_scale) else $error("current scale wrong");
  property p_drop; $rose(line_dropout_flag) |-> $past(loop_current_level) < `LVL_MIN; endproperty
  a_drop: assert property (p_drop) else $error("dropout without low level");
  property p_irq; dropout_irq |-> line_dropout_flag; endproperty
  a_irq: assert property (p_irq) else $error("irq without dropout");
  property p_ovl; $rose(overload_detected_flag) |-> $past(loop_current_level) == `LVL_MAX; endproperty
  a_ovl: assert property (p_ovl) else $error("overload without full level");
  property p_prot; $rose(overload_detected_flag) |-> dc_term_800 && hook_current_reduce; endproperty
  a_prot: assert property (p_prot) else $error("protection not applied");
  property p_gain; rx_gain_db <= 4'hc && rx_gain_db % 4'h3 == 4'h0; endproperty
  a_gain: assert property (p_gain) else $error("gain not a 3 dB step");
  property p_rxm;
    psel && penable && pready && pwrite && paddr == `OFS_GAIN && pstrb[0] |=> rx_mute == $past(pwdata[7]);
  endproperty
  a_rxm: assert property (p_rxm) else $error("rx mute not written");
  property p_txm;
    psel && penable && pready && pwrite && paddr == `OFS_GAIN && pstrb[1] |=> tx_mute == $past(pwdata[15]);
  endproperty
  a_txm: assert property (p_txm) else $error("tx mute not written");
  property p_path;
    $onehot0(loopback_path) && ((loopback_select == 3'h0 || loopback_select == 3'h7) == (loopback_path == 6'h00));
  endproperty
  a_path: assert property (p_path) else $error("loop path decode wrong");
  c_ovl: cover property ($rose(dc_term_800));
  c_irq: cover property ($rose(dropout_irq));
  c_err: cover property (pready && pslverr);
endmodule
bind daa_line_ctrl daa_line_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .pslverr, .off_hook, .loop_current_level, .loop_current_ua, .line_dropout_flag,
  .overload_detected_flag, .dropout_irq, .dc_term_800, .hook_current_reduce, .rx_gain_db, .rx_mute,
  .tx_mute, .loopback_select, .loopback_path);
`default_nettype wire

// ---- sim/line_side_model.sv ----
// Behavioural model of the line-side chip feeding hook state, current code and revision.
`default_nettype none
module line_side_model #(
  parameter logic [3:0] REV = 4'h9 // Arbitrary value.
) (
  // Control from the bench
  input wire logic pclk,
  input wire logic hook_req,
  input wire logic [4:0] level_req,
  // Pins
  output logic off_hook,
  output logic [4:0] current_code = 5'h00,
  output logic [3:0] revision
);
  // On-hook there is no measurement, so the code toggles rather than holding a stale value.
  always @(posedge pclk) begin
    off_hook <= hook_req;
    current_code <= hook_req ? level_req : ~current_code;
  end
  assign revision = REV;
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking testbench of the line status and test control block.
`include "daa_line_cfg.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic hook_req = 1'b0;
  logic [4:0] level_req = 5'h00;
  logic pready, pslverr, off_hook, line_dropout_flag, overload_detected_flag, dropout_irq, err;
  logic dc_term_800, hook_current_reduce, rx_mute, tx_mute, recursive_filter_select;
  logic [31:0] prdata, rdat;
  logic [4:0] line_current_code, loop_current_level;
  logic [3:0] line_chip_revision, rx_gain_db, tx_atten_db;
  logic [16:0] loop_current_ua;
  logic [15:0] sample_rate_hz;
  logic [2:0] loopback_select;
  logic [5:0] loopback_path;
  logic [15:0] rates [10] = '{16'h1c20, 16'h1f40, 16'h2025, 16'h20d0, 16'h2328, 16'h2580, 16'h282e,
    16'h2ee0, 16'h3592, 16'h3e80};
  logic [5:0] paths [8] = '{6'h00, 6'h08, 6'h10, 6'h02, 6'h04, 6'h01, 6'h20, 6'h00};
  int mismatches = 0;
  int checks = 0;
  always #5 pclk = ~pclk;
  daa_line_ctrl uut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .pslverr, .prdata, .off_hook, .line_current_code, .line_chip_revision, .loop_current_level,
    .loop_current_ua, .line_dropout_flag, .overload_detected_flag, .dropout_irq, .dc_term_800,
    .hook_current_reduce, .rx_gain_db, .rx_mute, .tx_atten_db, .tx_mute, .recursive_filter_select,
    .sample_rate_hz, .loopback_select, .loopback_path);
  line_side_model far (.pclk, .hook_req, .level_req, .off_hook, .current_code(line_current_code),
    .revision(line_chip_revision));
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // Outputs are read just after a rising edge, before the design's own updates of that edge land.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, exp, "read data");
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
    @(posedge pclk);
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(sample_rate_hz), 32'h1f40, "rate reset");
    chk(32'(recursive_filter_select), 32'h0, "filter reset");
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_RATE, 32'h1);
    hook_req <= 1'b1;
    level_req <= 5'h04;
    repeat (8) @(posedge pclk);
    rd(`OFS_STATUS, 32'h0009_0004);
    chk(32'(loop_current_ua), 32'h3390, "current scale");
    chk(32'(loop_current_level), 32'h4, "level port");
    for (int i = 0; i < 5; i++) begin
      wr(`OFS_GAIN, 32'(i) * 32'h101 | 32'(i % 2) * 32'h8080);
      chk(32'(rx_gain_db), 32'(i) * 32'h3, "rx gain");
      chk(32'(tx_atten_db), 32'(i) * 32'h3, "tx atten");
      chk(32'({rx_mute, tx_mute}), 32'(i % 2) * 32'h3, "mute");
    end
    wr(`OFS_GAIN, 32'h0000_0707);
    chk(32'({rx_gain_db, tx_atten_db}), 32'hcc, "gain clamp");
    for (int i = 0; i < 10; i++) begin
      wr(`OFS_RATE, 32'(i));
      chk(32'(sample_rate_hz), 32'(rates[i]), "rate");
    end
    wr(`OFS_RATE, 32'ha);
    chk(32'(sample_rate_hz), 32'h3e80, "bad rate kept");
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_CTRL, 32'(i) << 4 | 32'h4);
      chk(32'(loopback_path), 32'(paths[i]), "loop path");
      chk(32'(loopback_select), 32'(i), "loop select");
    end
    chk(32'(recursive_filter_select), 32'h1, "recursive filter");
    wr(`OFS_CTRL, 32'h2);
    level_req <= 5'h00;
    repeat (8) @(posedge pclk);
    chk(32'({line_dropout_flag, dropout_irq}), 32'h3, "dropout");
    level_req <= 5'h1f;
    wr(`OFS_CTRL, 32'h3);
    repeat (6) @(posedge pclk);
    rd(`OFS_STATUS, 32'h0009_031f);
    chk(32'({dc_term_800, hook_current_reduce}), 32'h3, "protection");
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_STATUS, 32'h300);
    chk(32'({line_dropout_flag, overload_detected_flag, dc_term_800}), 32'h0, "flags cleared");
    xfer(1'b0, 12'h010, 32'h0, rdat);
    chk(32'(err), 32'h1, "unmapped error");
    chk(rdat, 32'h0, "unmapped read data");
    complete_run;
  end
  initial begin
    repeat (4000) @(posedge pclk);
    mismatches++;
    complete_run;
  end
endmodule
`default_nettype wire
